// ===== sim/pfc_flash_model.sv
// behavioural flash device facing the host controller pins
`timescale 1ns/1ps
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter logic [15:0] ID_CODE = 16'h005E // arbitrary identification value
) (
  input wire logic clk_sys_in, // sampling clock of the model
  input wire logic ce_n_in, // chip enable
  input wire logic oe_n_in, // output enable
  input wire logic we_n_in, // write enable
  input wire logic reset_n_in, // reset pin
  input wire logic byte_n_in, // byte/word pin
  input wire pfc_acc_t acc_in, // accelerate pin
  input wire logic [20:0] addr_in, // address pins
  input wire logic dq15_addr_in, // lowest byte address
  input wire logic [15:0] dq_host_in, // host data out
  input wire logic [15:0] dq_oe_n_in, // host data enables
  output logic [15:0] dq_out, // resolved data wire
  output logic ready_busy_out // high ready
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] last_q = 16'h0000, rd, wd, pend_d;
  logic [20:0] wa, pend_a;
  logic wr_q = 0, arm_q = 0, auto_q = 0, kill_q = 0;
  int busy_q = 0;
  assign ready_busy_out = (busy_q == 0);
  always_comb begin
    rd = auto_q ? ID_CODE : (mem.exists(addr_in) ? mem[addr_in] : addr_in[15:0] ^ 16'h5A3C);
    if (!byte_n_in) rd = {8'h00, dq15_addr_in ? rd[15:8] : rd[7:0]};
  end
  // drive only while selected and reading
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!dq_oe_n_in[i]) dq_out[i] = dq_host_in[i];
      else if (reset_n_in && !ce_n_in && !oe_n_in && (byte_n_in || i < 8)) dq_out[i] = rd[i];
      else dq_out[i] = ~last_q[i];
    end
  end
  // write capture and command decode
  always @(posedge clk_sys_in) begin
    last_q <= dq_out;
    wr_q <= !we_n_in && !ce_n_in && reset_n_in;
    if (!we_n_in && !ce_n_in) begin
      wa <= addr_in;
      wd <= dq_host_in;
    end
    // program runs on; reset only discards it
    if (busy_q > 0) busy_q <= busy_q - 1;
    if (busy_q == 1 && !kill_q) mem[pend_a] = pend_d;
    if (!reset_n_in) begin
      arm_q <= 1'b0;
      auto_q <= 1'b0;
      kill_q <= 1'b1;
    end else if (wr_q && we_n_in) begin
      if (arm_q) begin
        arm_q <= 1'b0;
        if (acc_in != PFC_ACC_LOW || wa[20:15] != 6'h3F) begin
          pend_a <= wa;
          pend_d <= wd;
          kill_q <= 1'b0;
          busy_q <= 20;
        end
      end else if (wd == 16'h00A0) arm_q <= 1'b1;
      else if (wd == 16'h0090) auto_q <= 1'b1;
      else if (wd == 16'h00F0) auto_q <= 1'b0;
    end
  end
endmodule

// ===== sim/pfc_host_asserts.sv
// pin-level checker for the flash host controller
`timescale 1ns/1ps
module pfc_host_asserts
  import pfc_pkg::*;
(
  input wire logic clk_sys_in, // clock
  input wire logic nrst_in, // reset, active low
  input wire logic busy_out, // busy
  input wire logic done_out, // done pulse
  input wire logic ce_n_out, // chip enable
  input wire logic oe_n_out, // output enable
  input wire logic we_n_out, // write enable
  input wire logic reset_n_out, // flash reset pin
  input wire logic byte_n_out, // byte/word pin
  input wire pfc_acc_t protect_accel_pin_out, // accelerate pin
  input wire logic [20:0] addr_out, // address pins
  input wire logic [15:0] dq_oe_n_out // data enables
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_acc_defined; protect_accel_pin_out inside {PFC_ACC_LOW, PFC_ACC_HIGH, PFC_ACC_HV}; endproperty
  a_acc_defined: assert property (p_acc_defined) else $error("accel pin undefined");
  // high voltage only in an operation
  property p_hv_busy; protect_accel_pin_out == PFC_ACC_HV |-> busy_out || done_out; endproperty
  a_hv_busy: assert property (p_hv_busy) else $error("high voltage while idle");
  property p_hv_settle; $rose(protect_accel_pin_out == PFC_ACC_HV) |-> we_n_out; endproperty
  a_hv_settle: assert property (p_hv_settle) else $error("write with fresh high voltage");
  // no contention while reading; top pin is an address in byte mode
  property p_read_float;
    !oe_n_out |-> &dq_oe_n_out[14:0] && (!byte_n_out || dq_oe_n_out[15]);
  endproperty
  a_read_float: assert property (p_read_float) else $error("host drives data in read");
  // upper byte below the top pin floated in byte mode
  property p_byte_float; !byte_n_out |-> &dq_oe_n_out[14:8]; endproperty
  a_byte_float: assert property (p_byte_float) else $error("upper byte driven");
  property p_read_sel; $fell(oe_n_out) |-> !ce_n_out && we_n_out; endproperty
  a_read_sel: assert property (p_read_sel) else $error("read without select");
  // address held until the read strobe ends
  property p_read_addr; $rose(oe_n_out) |-> $stable(addr_out); endproperty
  a_read_addr: assert property (p_read_addr) else $error("address moved in read");
  property p_rst_pulse; $fell(reset_n_out) |-> !reset_n_out [*5]; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
  property p_rst_rec; $rose(reset_n_out) |-> oe_n_out && we_n_out; endproperty
  a_rst_rec: assert property (p_rst_rec) else $error("access at reset release");
  property p_write; !we_n_out |-> oe_n_out && !ce_n_out && dq_oe_n_out[7:0] == 8'h00; endproperty
  a_write: assert property (p_write) else $error("bad write cycle");
  c_hv: cover property (protect_accel_pin_out == PFC_ACC_HV);
  c_rst: cover property ($fell(reset_n_out));
  c_byte_read: cover property (!byte_n_out && !oe_n_out);
endmodule
bind pfc_host pfc_host_asserts u_pfc_host_asserts (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .busy_out(busy_out), .done_out(done_out),
  .ce_n_out(ce_n_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out), .reset_n_out(reset_n_out),
  .byte_n_out(byte_n_out), .protect_accel_pin_out(protect_accel_pin_out),
  .addr_out(addr_out), .dq_oe_n_out(dq_oe_n_out)
);

// ===== sim/pfc_host_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module pfc_host_test;
  import pfc_pkg::*;
  localparam logic [15:0] ID_CODE = 16'h005E; // arbitrary identification value
  logic clk_sys_in, nrst_in, req_in, word_mode_in, protect_in, hv_seen;
  pfc_op_t op_in;
  logic [21:0] addr_in;
  logic [15:0] wdata_in, rdata_out, dq_in, dq_out, dq_oe_n_out;
  logic busy_out, done_out, retry_out, ce_n_out, oe_n_out, we_n_out, reset_n_out;
  logic byte_n_out, dq15_addr_out, ready_busy_in;
  logic [5:0] sector_index_out;
  logic [20:0] addr_out;
  pfc_acc_t protect_accel_pin_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  pfc_host u_pfc_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req_in),
    .op_in(op_in), .addr_in(addr_in), .wdata_in(wdata_in), .word_mode_in(word_mode_in),
    .protect_in(protect_in), .ready_busy_in(ready_busy_in), .dq_in(dq_in),
    .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
    .sector_index_out(sector_index_out), .retry_out(retry_out), .ce_n_out(ce_n_out),
    .oe_n_out(oe_n_out), .we_n_out(we_n_out), .reset_n_out(reset_n_out),
    .byte_n_out(byte_n_out), .protect_accel_pin_out(protect_accel_pin_out),
    .addr_out(addr_out), .dq15_addr_out(dq15_addr_out), .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out));
  pfc_flash_model #(.ID_CODE(ID_CODE)) u_pfc_flash_model (.clk_sys_in(clk_sys_in),
    .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out), .reset_n_in(reset_n_out),
    .byte_n_in(byte_n_out), .acc_in(protect_accel_pin_out), .addr_in(addr_out),
    .dq15_addr_in(dq15_addr_out), .dq_host_in(dq_out), .dq_oe_n_in(dq_oe_n_out),
    .dq_out(dq_in), .ready_busy_out(ready_busy_in));
  // clock generator
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // cycle ceiling and high-voltage monitor
  always @(posedge clk_sys_in) begin
    cycles++;
    if (protect_accel_pin_out === PFC_ACC_HV) hv_seen = 1'b1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic note(input bit ok, input string what);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    note(got === exp, $sformatf("data %h expected %h", got, exp));
  endtask
  task automatic chk_sect(input logic [5:0] got, input logic [5:0] exp);
    note(got === exp, $sformatf("sector %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    note(got === exp, $sformatf("flag %b expected %b", got, exp));
  endtask
  function automatic logic [15:0] pat(input logic [20:0] w);
    return w[15:0] ^ 16'h5A3C;
  endfunction
  // bounded wait for the done pulse
  task automatic wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 500) begin
      @(posedge clk_sys_in);
      n++;
    end
    note(n < 500, "operation did not finish");
  endtask
  // one request, then a bounded wait for done
  task automatic run_op(input pfc_op_t op, input logic [21:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    op_in <= op;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    wait_done();
  endtask
  task automatic t_read(input logic [21:0] a, input logic [15:0] exp);
    run_op(PFC_OP_READ, a, 16'h0000);
    chk_data(rdata_out, exp);
    chk_sect(sector_index_out, word_mode_in ? a[20:15] : a[21:16]);
  endtask
  task automatic t_word_reads();
    t_read(22'h012345, pat(21'h012345));
    t_read(22'h018000, pat(21'h018000));
    t_read(22'h01FFFF, pat(21'h01FFFF));
  endtask
  task automatic t_byte_reads();
    word_mode_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    t_read(22'h00ABCD, 16'h000F);
    t_read(22'h00ABCC, 16'h00DA);
    word_mode_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic t_prog_accel();
    protect_in <= 1'b0;
    run_op(PFC_OP_PROG, 22'h000100, 16'h1234);
    t_read(22'h000100, 16'h1234);
    protect_in <= 1'b1;
    hv_seen = 1'b0;
    run_op(PFC_OP_ACCEL_PROG, 22'h1F8010, 16'hBEEF);
    chk_bit(hv_seen, 1'b1);
    @(posedge clk_sys_in);
    chk_bit(protect_accel_pin_out === PFC_ACC_LOW, 1'b1);
    t_read(22'h1F8010, 16'hBEEF);
    run_op(PFC_OP_PROG, 22'h1F8020, 16'h7777);
    t_read(22'h1F8020, 16'hDA1C);
  endtask
  task automatic t_autosel(input pfc_op_t leave);
    run_op(PFC_OP_AUTOSEL, 22'h000000, 16'h0000);
    chk_data(rdata_out, ID_CODE);
    run_op(leave, 22'h000000, 16'h0000);
    t_read(22'h000000, pat(21'h000000));
    chk_bit(reset_n_out, 1'b1);
    chk_bit(retry_out, 1'b0);
  endtask
  // hardware reset while a program runs, then reissue it
  task automatic t_reset_abort();
    int n;
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    op_in <= PFC_OP_PROG;
    addr_in <= 22'h000200;
    wdata_in <= 16'h4321;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    n = 0;
    while (ready_busy_in !== 1'b0 && n < 100) begin
      @(posedge clk_sys_in);
      n++;
    end
    note(n < 100, "program never went busy");
    repeat (3) @(posedge clk_sys_in);
    req_in <= 1'b1;
    op_in <= PFC_OP_HW_RESET;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    wait_done();
    chk_bit(ready_busy_in, 1'b1);
    chk_bit(retry_out, 1'b1);
    t_read(22'h000200, pat(21'h000200));
    run_op(PFC_OP_PROG, 22'h000200, 16'h4321);
    t_read(22'h000200, 16'h4321);
    chk_bit(retry_out, 1'b0);
  endtask
  // main sequence
  initial begin
    nrst_in = 1'b0;
    req_in = 1'b0;
    op_in = PFC_OP_READ;
    addr_in = 22'h000000;
    wdata_in = 16'h0000;
    word_mode_in = 1'b1;
    protect_in = 1'b1;
    hv_seen = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_word_reads();
    t_byte_reads();
    t_prog_accel();
    t_autosel(PFC_OP_RESET_CMD);
    t_autosel(PFC_OP_HW_RESET);
    t_reset_abort();
    give_verdict();
  end
endmodule

// ===== verilog/pfc_cyc_if.sv
// single bus cycle request/response between the sequencer and the cycle engine
`timescale 1ns/1ps
interface pfc_cyc_if;
  logic req;
  logic wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport seq (output req, output wr, output addr, output wdata, input rdata, input done);
  modport eng (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface

// ===== verilog/pfc_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_cycle (
  input wire logic clk_sys_in, // system clock
  input wire logic nrst_in, // async reset, active low
  pfc_cyc_if.eng cyc, // cycle request
  input wire logic word_mode_in, // word configuration
  input wire logic [15:0] dq_in, // data pins in
  output logic ce_n_out, // chip enable
  output logic oe_n_out, // output enable
  output logic we_n_out, // write enable
  output logic [20:0] addr_out, // word address pins
  output logic dq15_addr_out, // lowest byte address on top data pin
  output logic [15:0] dq_out, // data pins out
  output logic [15:0] dq_oe_n_out // data pin enable, low drives
);
  import pfc_pkg::*;
  typedef enum logic [1:0] {PFC_CY_IDLE, PFC_CY_RUN, PFC_CY_DONE} pfc_cy_t;
  pfc_cy_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  logic [7:0] need;

  // read waits the longer of address and select access; write the pulse width
  always_comb begin
    need = wr_q ? 8'(`PFC_CYC_WP) :
      ((`PFC_CYC_CE > `PFC_CYC_ACC) ? 8'(`PFC_CYC_CE) : 8'(`PFC_CYC_ACC));
  end

  // cycle sequencing and strobes
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= PFC_CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      addr_out <= 21'h000000;
      dq15_addr_out <= 1'b0;
      dq_out <= 16'h0000;
      dq_oe_n_out <= 16'hFFFF;
      cyc.rdata <= 16'h0000;
      cyc.done <= 1'b0;
    end else begin
      cyc.done <= 1'b0;
      unique case (st_q)
        PFC_CY_IDLE: begin
          if (cyc.req) begin
            st_q <= PFC_CY_RUN;
            cnt_q <= 8'h00;
            wr_q <= cyc.wr;
            ce_n_out <= 1'b0;
            oe_n_out <= cyc.wr;
            we_n_out <= !cyc.wr;
            // RULE20 byte mode address
            addr_out <= word_mode_in ? cyc.addr[20:0] : cyc.addr[21:1];
            dq15_addr_out <= word_mode_in ? 1'b0 : cyc.addr[0];
            // RULE20 top data pin carries the lowest byte address
            dq_out <= word_mode_in ? cyc.wdata : {cyc.addr[0], cyc.wdata[14:0]};
            dq_oe_n_out <= cyc.wr ? (word_mode_in ? 16'h0000 : 16'h7F00) :
              (word_mode_in ? 16'hFFFF : 16'h7FFF);
          end
        end
        PFC_CY_RUN: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q + 8'h01 >= need) begin
            // RULE6 codes on low byte
            if (!wr_q) cyc.rdata <= word_mode_in ? dq_in : {8'h00, dq_in[7:0]};
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            dq_oe_n_out <= word_mode_in ? 16'hFFFF : 16'h7FFF;
            st_q <= PFC_CY_DONE;
          end
        end
        PFC_CY_DONE: begin
          cyc.done <= 1'b1;
          st_q <= PFC_CY_IDLE;
        end
        default: st_q <= PFC_CY_IDLE;
      endcase
    end
  end
endmodule

// ===== verilog/pfc_defs.svh
// timing counts, unlock addresses and command constants for the flash host controller
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
`define PFC_CLK_NS 100
`define PFC_T_ACC_NS 90
`define PFC_T_CE_NS 90
`define PFC_T_RP_NS 500
`define PFC_T_RH_NS 50
`define PFC_T_READY_NS 20000
`define PFC_T_WP_NS 35
`define PFC_CYC_ACC ((`PFC_T_ACC_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_CE ((`PFC_T_CE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_RP ((`PFC_T_RP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_RH ((`PFC_T_RH_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_READY ((`PFC_T_READY_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_WP ((`PFC_T_WP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_ADDR_W 22
`define PFC_UNLOCK1_ADDR 22'h000555
`define PFC_UNLOCK2_ADDR 22'h0002AA
`define PFC_UNLOCK1_DATA 16'h00AA
`define PFC_UNLOCK2_DATA 16'h0055
`define PFC_CMD_PROG 16'h00A0
`define PFC_CMD_AUTOSEL 16'h0090
`define PFC_CMD_BYPASS 16'h0020
`define PFC_CMD_RESET 16'h00F0
`define PFC_SECT_LSB 15
`define PFC_SECT_MSB 20
`endif

// ===== verilog/pfc_host.sv
// host controller driving an asynchronous parallel NOR flash through its pins
// Behaviour
// (RULE1) device enters bypass and unprotects while accelerate pin at high voltage
// (RULE2) accelerated programming uses the two-cycle bypass program command
// (RULE3) removing high voltage returns the device to normal protection
// (RULE4) high programming voltage applied only during accelerated programming
// (RULE5) protect_accel_pin is always driven to a defined level
// (RULE6) autoselect codes read on the low data byte with normal timing
// (RULE7) device floats data outputs in standby regardless of output enable
// (RULE8) standby with select and reset high; reads need select access time
// (RULE9) deselecting during program or erase does not stop it
// (RULE10) device sleeps once address stable for access time plus 30 ns
// (RULE11) any address change yields new data within address access time
// (RULE12) reset low for minimum pulse aborts operation and floats outputs
// (RULE13) hardware reset returns device to read-array mode
// (RULE14) host reissues a program cut short by hardware reset
// (RULE15) reset during program keeps ready/busy low until internal reset ends
// (RULE16) reset while idle completes within idle reset-ready time
// (RULE17) host waits reset-high recovery before the next read
// (RULE18) output enable high floats all device data pins
// (RULE19) upper address bits select uniform 64 Kbyte sectors, low three ignored
// (RULE20) byte pin selects 16-bit or low-byte path with top pin as address
// (RULE21) bypass programming takes two write cycles instead of four
// (RULE22) accelerate pin modelled as low, high or high voltage
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_host (
  input wire logic clk_sys_in, // 10 MHz system clock
  input wire logic nrst_in, // async reset, active low
  input wire logic req_in, // start an operation, pulse
  input wire pfc_pkg::pfc_op_t op_in, // operation kind
  input wire logic [21:0] addr_in, // word address in word mode, byte address in byte mode
  input wire logic [15:0] wdata_in, // program data
  input wire logic word_mode_in, // 1 word, 0 byte configuration
  input wire logic protect_in, // keep boot sectors protected when not accelerating
  input wire logic ready_busy_in, // device ready/busy pin, high ready
  input wire logic [15:0] dq_in, // data pins in
  output logic busy_out, // operation in progress
  output logic done_out, // operation finished, pulse
  output logic [15:0] rdata_out, // read data
  output logic [5:0] sector_index_out, // sector of last access
  output logic retry_out, // interrupted program needs reissue
  output logic ce_n_out, // chip enable, active low
  output logic oe_n_out, // output enable, active low
  output logic we_n_out, // write enable, active low
  output logic reset_n_out, // hardware reset pin, active low
  output logic byte_n_out, // byte/word select, high word
  output pfc_pkg::pfc_acc_t protect_accel_pin_out, // accelerate pin level
  output logic [20:0] addr_out, // address pins
  output logic dq15_addr_out, // top data pin as lowest address
  output logic [15:0] dq_out, // data pins out
  output logic [15:0] dq_oe_n_out // data pin enables, low drives
);
  import pfc_pkg::*;
  typedef enum logic [2:0] {
    PFC_S_IDLE, PFC_S_ACC_ON, PFC_S_CYC, PFC_S_WAIT, PFC_S_POLL, PFC_S_RST_LO,
    PFC_S_RST_RDY, PFC_S_RST_HI
  } pfc_st_t;
  pfc_cyc_if cyc ();
  pfc_st_t st_q;
  pfc_op_t op_q;
  logic [21:0] addr_q;
  logic [15:0] wdata_q;
  logic [2:0] step_q;
  logic [2:0] nsteps_q;
  logic [15:0] tmr_q;
  logic cyc_req_q;
  logic cyc_wr;
  logic [21:0] cyc_addr;
  logic [15:0] cyc_wdata;

  // RULE19 sector decode from upper address bits
  // word mode counts word addresses, byte mode byte addresses one bit higher
  function automatic logic [5:0] sect_of(input logic [21:0] a, input logic wm);
    sect_of = wm ? a[`PFC_SECT_MSB:`PFC_SECT_LSB] : a[`PFC_SECT_MSB+1:`PFC_SECT_LSB+1];
  endfunction

  // the command sequence: address and data for each step of each operation
  always_comb begin
    cyc_wr = 1'b1;
    cyc_addr = `PFC_UNLOCK1_ADDR;
    cyc_wdata = `PFC_UNLOCK1_DATA;
    unique case (op_q)
      PFC_OP_READ: begin
        cyc_wr = (step_q != nsteps_q - 3'd1) ? 1'b1 : 1'b0;
        cyc_addr = addr_q;
      end
      PFC_OP_ACCEL_PROG: begin
        // RULE2 two-cycle bypass program
        cyc_wdata = (step_q == 3'd0) ? `PFC_CMD_PROG : wdata_q;
        cyc_addr = (step_q == 3'd0) ? 22'h000000 : addr_q;
      end
      PFC_OP_PROG, PFC_OP_AUTOSEL: begin
        unique case (step_q)
          3'd0: cyc_wdata = `PFC_UNLOCK1_DATA;
          3'd1: begin
            cyc_addr = `PFC_UNLOCK2_ADDR;
            cyc_wdata = `PFC_UNLOCK2_DATA;
          end
          3'd2: cyc_wdata = (op_q == PFC_OP_PROG) ? `PFC_CMD_PROG : `PFC_CMD_AUTOSEL;
          default: begin
            // program data write, or RULE6 autoselect code read
            cyc_wr = (op_q == PFC_OP_PROG);
            cyc_addr = addr_q;
            cyc_wdata = wdata_q;
          end
        endcase
      end
      default: begin
        cyc_addr = 22'h000000;
        cyc_wdata = `PFC_CMD_RESET;
      end
    endcase
  end

  assign cyc.req = cyc_req_q;
  assign cyc.wr = cyc_wr;
  assign cyc.addr = cyc_addr;
  assign cyc.wdata = cyc_wdata;

  pfc_cycle u_cycle (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .cyc(cyc),
    .word_mode_in(word_mode_in),
    .dq_in(dq_in),
    .ce_n_out(ce_n_out),
    .oe_n_out(oe_n_out),
    .we_n_out(we_n_out),
    .addr_out(addr_out),
    .dq15_addr_out(dq15_addr_out),
    .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out)
  );

  // operation sequencer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= PFC_S_IDLE;
      op_q <= PFC_OP_READ;
      addr_q <= 22'h000000;
      wdata_q <= 16'h0000;
      step_q <= 3'd0;
      nsteps_q <= 3'd1;
      tmr_q <= 16'h0000;
      cyc_req_q <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
      sector_index_out <= 6'h00;
      reset_n_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      cyc_req_q <= 1'b0;
      unique case (st_q)
        PFC_S_IDLE: begin
          if (req_in) begin
            op_q <= op_in;
            addr_q <= addr_in;
            wdata_q <= wdata_in;
            sector_index_out <= sect_of(addr_in, word_mode_in);
            step_q <= 3'd0;
            busy_out <= 1'b1;
            tmr_q <= 16'h0000;
            unique case (op_in)
              PFC_OP_READ: nsteps_q <= 3'd1;
              PFC_OP_ACCEL_PROG: nsteps_q <= 3'd2;
              PFC_OP_PROG, PFC_OP_AUTOSEL: nsteps_q <= 3'd4;
              default: nsteps_q <= 3'd1;
            endcase
            if (op_in == PFC_OP_HW_RESET) begin
              reset_n_out <= 1'b0;
              st_q <= PFC_S_RST_LO;
            end else if (op_in == PFC_OP_ACCEL_PROG) begin
              st_q <= PFC_S_ACC_ON;
            end else begin
              cyc_req_q <= 1'b1;
              st_q <= PFC_S_CYC;
            end
          end
        end
        PFC_S_ACC_ON: begin
          // let the accelerate pin settle before the first write
          cyc_req_q <= 1'b1;
          st_q <= PFC_S_CYC;
        end
        PFC_S_CYC: begin
          if (cyc.done) begin
            if (step_q + 3'd1 >= nsteps_q) begin
              rdata_out <= cyc.rdata;
              if (op_q == PFC_OP_PROG || op_q == PFC_OP_ACCEL_PROG) begin
                tmr_q <= 16'h0000;
                st_q <= PFC_S_WAIT;
              end else begin
                busy_out <= 1'b0;
                done_out <= 1'b1;
                st_q <= PFC_S_IDLE;
              end
            end else begin
              step_q <= step_q + 3'd1;
              cyc_req_q <= 1'b1;
            end
          end
        end
        PFC_S_WAIT: begin
          // give ready/busy time to fall before polling it
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'h0001) st_q <= PFC_S_POLL;
        end
        PFC_S_POLL: begin
          if (ready_busy_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            st_q <= PFC_S_IDLE;
          end else if (req_in && op_in == PFC_OP_HW_RESET) begin
            // RULE14 hardware reset may cut a running program short
            op_q <= op_in;
            tmr_q <= 16'h0000;
            reset_n_out <= 1'b0;
            st_q <= PFC_S_RST_LO;
          end
        end
        PFC_S_RST_LO: begin
          // RULE12 hold reset low for minimum pulse
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q + 16'h0001 >= 16'(`PFC_CYC_RP)) begin
            reset_n_out <= 1'b1;
            tmr_q <= 16'h0000;
            st_q <= PFC_S_RST_RDY;
          end
        end
        PFC_S_RST_RDY: begin
          // RULE15 wait ready/busy high, bounded by reset-ready time
          tmr_q <= tmr_q + 16'h0001;
          if (ready_busy_in || tmr_q + 16'h0001 >= 16'(`PFC_CYC_READY)) begin
            tmr_q <= 16'h0000;
            st_q <= PFC_S_RST_HI;
          end
        end
        PFC_S_RST_HI: begin
          // RULE17 reset-high recovery before any read
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q + 16'h0001 >= 16'(`PFC_CYC_RH)) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            st_q <= PFC_S_IDLE;
          end
        end
        default: st_q <= PFC_S_IDLE;
      endcase
    end
  end

  // RULE14 flag a program cut short by hardware reset for reissue
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      retry_out <= 1'b0;
    end else begin
      // set when a reset lands while the device still reports busy
      if (req_in && st_q == PFC_S_POLL && !ready_busy_in && op_in == PFC_OP_HW_RESET)
        retry_out <= 1'b1;
      else if (req_in && st_q == PFC_S_IDLE) retry_out <= 1'b0;
    end
  end

  // RULE4 high voltage only in accelerated programming; RULE5 always driven
  // RULE22 three-level accelerate pin
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      protect_accel_pin_out <= PFC_ACC_LOW;
      byte_n_out <= 1'b1;
    end else begin
      byte_n_out <= word_mode_in;
      if (st_q != PFC_S_IDLE && op_q == PFC_OP_ACCEL_PROG) protect_accel_pin_out <= PFC_ACC_HV;
      else if (st_q == PFC_S_IDLE && req_in && op_in == PFC_OP_ACCEL_PROG)
        protect_accel_pin_out <= PFC_ACC_HV;
      else protect_accel_pin_out <= protect_in ? PFC_ACC_LOW : PFC_ACC_HIGH;
    end
  end
endmodule

// ===== verilog/pfc_pkg.sv
// types shared by the flash host controller
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ,
    PFC_OP_PROG,
    PFC_OP_ACCEL_PROG,
    PFC_OP_AUTOSEL,
    PFC_OP_RESET_CMD,
    PFC_OP_HW_RESET
  } pfc_op_t;
  // accelerate pin state: low, high, high programming voltage
  typedef enum logic [1:0] {
    PFC_ACC_LOW,
    PFC_ACC_HIGH,
    PFC_ACC_HV
  } pfc_acc_t;
endpackage
